// File: hdl/ipm_pkg.sv
// Constants, register map and field positions of the internal port error monitor.
// Assumes a 16-bit register port with one-cycle read latency.
package ipm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] PERIPH_PORT_CONFIG_OFS       = 16'h0100;
  localparam logic [15:0] PERIPH_PORT_ERROR_STATUS_OFS = 16'h0102;
  localparam logic [15:0] MEMORY_PORT_CONFIG_OFS       = 16'h0200;
  localparam logic [15:0] MEMORY_PORT_ERROR_STATUS_OFS = 16'h0202;
  localparam logic [15:0] TIMEOUT_CONTROL_OFS          = 16'h9000;
  localparam logic [15:0] IDLE_CONTROL_OFS             = 16'h0001;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int INV_ERR_EN_BIT    = 15;
  localparam int INV_ERR_FLAG_BIT  = 15;
  localparam int PERI_TO_FLAG_BIT  = 12;
  localparam int WR_BUS_ERR_BIT    = 4;
  localparam int RD_BUS_ERR_BIT    = 3;
  localparam int WPE_BIT           = 7;
  localparam int EXT_TO_FLAG_BIT   = 12;
  localparam int PERI_TO_EN_BIT    = 1;
  localparam int EXT_TO_EN_BIT     = 0;
  localparam int PERI_IDLE_REQ_BIT = 0;
  localparam int MEM_IDLE_REQ_BIT  = 1;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic       INV_ERR_EN_RST  = 1'b1;
  localparam logic       WPE_RST         = 1'b0;
  localparam logic [1:0] TIMEOUT_CONTROL_REG_RST        = 2'h0;
  localparam logic [1:0] ICR_RST         = 2'h0;

  // ****************************************
  // Covered I/O ranges
  // ****************************************
  localparam logic [15:0] RANGE0_LO = 16'h0000;
  localparam logic [15:0] RANGE0_HI = 16'h03ff;
  localparam logic [15:0] RANGE1_LO = 16'h1400;
  localparam logic [15:0] RANGE1_HI = 16'h17ff;
  localparam logic [15:0] RANGE2_LO = 16'h2000;
  localparam logic [15:0] RANGE2_HI = 16'h23ff;

  // ****************************************
  // Timing
  // ****************************************
  localparam int TIMEOUT_CYCLES  = 512;
  localparam int POST_DEPTH      = 2;

  typedef enum logic [1:0] {IPM_IDLE, IPM_BUSY, IPM_HANG} ipm_state_type;

endpackage : ipm_pkg

// File: hdl/ipm_timeout.sv
// Watchdog counter that flags an access left unanswered for a set number of cycles.
// Assumes start/busy are from logic on the same clock.
`timescale 1ns/100ps
module ipm_timeout
  import ipm_pkg::*;
#(
  parameter int LIMIT = TIMEOUT_CYCLES
) (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic enable_i,
  input  wire logic waiting_i,
  output logic      expired_o
);
  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic [CW-1:0] count;
  logic          fired;

  wire hit = enable_i && waiting_i && !fired && (count == LAST);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !waiting_i) begin
      count <= '0;
      fired <= 1'b0;
    end else if (!fired) begin
      count <= count + CW'(1);
      fired <= hit;
    end
  end

  assign expired_o = hit;
endmodule : ipm_timeout

// File: hdl/ipm_write_post.sv
// Two-entry write posting buffer between the CPU write buses and the memory interface.
// Assumes the memory interface drains one entry per accepted cycle.
`timescale 1ns/100ps
module ipm_write_post
  import ipm_pkg::*;
#(
  parameter int AW    = 24,
  parameter int DW    = 16,
  parameter int DEPTH = POST_DEPTH
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  input  wire logic          push_i,
  input  wire logic [AW-1:0] push_addr_i,
  input  wire logic [DW-1:0] push_data_i,
  output logic               full_o,
  output logic               empty_o,
  output logic [AW-1:0]      head_addr_o,
  output logic [DW-1:0]      head_data_o,
  input  wire logic          pop_i
);
  localparam int PW = $clog2(DEPTH);

  logic [AW-1:0] addr_mem [DEPTH];
  logic [DW-1:0] data_mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0]   level;

  wire do_push = push_i && !full_o;
  wire do_pop  = pop_i && !empty_o;

  assign full_o      = (level == (PW+1)'(DEPTH));
  assign empty_o     = (level == '0);
  assign head_addr_o = addr_mem[rd_ptr];
  assign head_data_o = data_mem[rd_ptr];

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      level <= level + (PW+1)'(do_push) - (PW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (do_push) begin
      addr_mem[wr_ptr] <= push_addr_i;
      data_mem[wr_ptr] <= push_data_i;
    end
  end
endmodule : ipm_write_post

// File: hdl/ipm_top.sv
// The implementer's own choice: the plain strobed port.
`timescale 1ns/100ps
module ipm_top
  import ipm_pkg::*;
#(
  parameter int AW = 24,
  parameter int DW = 16
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_n_i,
  // Register port
  input  wire logic [15:0]   reg_addr_i,
  input  wire logic [15:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [15:0]   reg_rdata_o,
  // CPU side of the peripheral port
  input  wire logic          pp_req_i,
  input  wire logic          pp_write_i,
  input  wire logic [15:0]   pp_addr_i,
  input  wire logic          pp_invalid_i,
  output logic               pp_stall_o,
  output logic               pp_req_o,
  input  wire logic          pp_ack_i,
  // Idle handshake
  input  wire logic          idle_instr_i,
  input  wire logic          cpu_idle_i,
  input  wire logic          master_idle_i,
  output logic               pp_idle_o,
  output logic               mp_idle_o,
  // CPU writes toward external memory (two write buses)
  input  wire logic          wr_e_i,
  input  wire logic [AW-1:0] wr_e_addr_i,
  input  wire logic [DW-1:0] wr_e_data_i,
  input  wire logic          wr_f_i,
  input  wire logic [AW-1:0] wr_f_addr_i,
  input  wire logic [DW-1:0] wr_f_data_i,
  output logic               mp_stall_o,
  // External memory interface side
  output logic               emi_wr_o,
  output logic [AW-1:0]      emi_addr_o,
  output logic [DW-1:0]      emi_data_o,
  input  wire logic          emi_ready_i,
  input  wire logic          emi_busy_i,
  output logic               bus_error_o
);

  // ****************************************
  // Registers
  // ****************************************
  logic invalid_access_err_enable;
  logic write_posting_enable;
  logic periph_timeout_enable;
  logic ext_mem_timeout_enable;
  logic periph_port_idle_req;
  logic memory_port_idle_req;
  logic invalid_access_err_flag;
  logic write_bus_err_flag;
  logic read_bus_err_flag;
  logic periph_timeout_flag;
  logic ext_mem_timeout_flag;
  logic pp_idle;
  logic mp_idle;
  logic f_pending;
  logic [AW-1:0] f_addr;
  logic [DW-1:0] f_data;
  logic [15:0] rdata;

  // ****************************************
  // Decode
  // ****************************************
  wire sel_ppc  = (reg_addr_i == PERIPH_PORT_CONFIG_OFS);
  wire sel_ppe  = (reg_addr_i == PERIPH_PORT_ERROR_STATUS_OFS);
  wire sel_mpc  = (reg_addr_i == MEMORY_PORT_CONFIG_OFS);
  wire sel_mpe  = (reg_addr_i == MEMORY_PORT_ERROR_STATUS_OFS);
  wire sel_toc  = (reg_addr_i == TIMEOUT_CONTROL_OFS);
  wire sel_icr  = (reg_addr_i == IDLE_CONTROL_OFS);

  wire in_r0 = (pp_addr_i >= RANGE0_LO) && (pp_addr_i <= RANGE0_HI);
  wire in_r1 = (pp_addr_i >= RANGE1_LO) && (pp_addr_i <= RANGE1_HI);
  wire in_r2 = (pp_addr_i >= RANGE2_LO) && (pp_addr_i <= RANGE2_HI);
  wire in_scope = in_r0 || in_r1 || in_r2;

  // Invalid access detected only while awake; it is an error with the feature on, a hang with it off
  wire inv_access = pp_req_i && pp_invalid_i && in_scope && !pp_idle;
  wire inv_err    = inv_access && invalid_access_err_enable;
  wire inv_hang   = inv_access && !invalid_access_err_enable;

  // ****************************************
  // Peripheral port forwarding and stall
  // ****************************************
  logic pp_waiting;
  logic pp_hung;
  wire  pp_to;

  // Idle port forwards nothing and holds the requester
  assign pp_req_o   = pp_req_i && !pp_idle && !inv_access && !pp_hung;
  // A forwarded request holds the requester from its first cycle until answer or time-out
  assign pp_stall_o = (pp_req_i && (pp_idle || inv_hang || pp_hung)) ||
                      ((pp_req_o || pp_waiting) && !pp_ack_i && !pp_to);

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pp_waiting <= 1'b0;
      pp_hung    <= 1'b0;
    end else begin
      pp_waiting <= (pp_req_o || pp_waiting) && !pp_ack_i && !pp_to;
      pp_hung    <= (pp_hung || inv_hang) && rst_n_i;
    end
  end

  ipm_timeout #(
    .LIMIT     (TIMEOUT_CYCLES)
  ) u_pp_timeout (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .enable_i  (periph_timeout_enable),
    .waiting_i (pp_waiting),
    .expired_o (pp_to)
  );

  // ****************************************
  // Memory data port posting
  // ****************************************
  wire post_full;
  wire post_empty;
  wire [AW-1:0] head_addr;
  wire [DW-1:0] head_data;

  // E bus first, F bus held at least one cycle in f_pending and pushed only when E is not
  wire accept_ok = !mp_idle && write_posting_enable && !post_full;
  wire push_e    = wr_e_i && accept_ok;
  wire push_f    = f_pending && accept_ok && !push_e;
  wire push      = push_e || push_f;
  wire pop       = !post_empty && emi_ready_i && !mp_idle;

  // Without posting each write waits for the memory interface directly
  wire direct     = !write_posting_enable && !mp_idle && (wr_e_i || f_pending);
  assign mp_stall_o = mp_idle ? (wr_e_i || f_pending) :
                      write_posting_enable ? (post_full && (wr_e_i || f_pending)) || (wr_e_i && f_pending) :
                      (direct && !emi_ready_i);

  ipm_write_post #(
    .AW          (AW),
    .DW          (DW),
    .DEPTH       (POST_DEPTH)
  ) u_post (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_n_i),
    .push_i      (push),
    .push_addr_i (push_e ? wr_e_addr_i : f_addr),
    .push_data_i (push_e ? wr_e_data_i : f_data),
    .full_o      (post_full),
    .empty_o     (post_empty),
    .head_addr_o (head_addr),
    .head_data_o (head_data),
    .pop_i       (pop)
  );

  wire f_take = wr_f_i && !f_pending;
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      f_pending <= 1'b0;
      f_addr    <= '0;
      f_data    <= '0;
    end else begin
      f_pending <= f_take || (f_pending && !push_f && !(direct && !wr_e_i && emi_ready_i));
      if (f_take) begin
        f_addr <= wr_f_addr_i;
        f_data <= wr_f_data_i;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      emi_wr_o   <= 1'b0;
      emi_addr_o <= '0;
      emi_data_o <= '0;
    end else begin
      emi_wr_o <= pop || (direct && emi_ready_i);
      if (pop) begin
        emi_addr_o <= head_addr;
        emi_data_o <= head_data;
      end else if (direct) begin
        emi_addr_o <= wr_e_i ? wr_e_addr_i : f_addr;
        emi_data_o <= wr_e_i ? wr_e_data_i : f_data;
      end
    end
  end

  wire mp_to;
  ipm_timeout #(
    .LIMIT     (TIMEOUT_CYCLES)
  ) u_mp_timeout (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .enable_i  (ext_mem_timeout_enable),
    .waiting_i (emi_busy_i),
    .expired_o (mp_to)
  );

  // ****************************************
  // Idle entry and illegal idle
  // ****************************************
  wire go_pp_idle = periph_port_idle_req && idle_instr_i && !pp_idle;
  wire go_mp_idle = memory_port_idle_req && idle_instr_i && !mp_idle;
  wire others_awake = !(cpu_idle_i && master_idle_i);
  wire idle_err = (go_pp_idle || go_mp_idle) && others_awake;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pp_idle <= 1'b0;
      mp_idle <= 1'b0;
    end else begin
      pp_idle <= (pp_idle || go_pp_idle) && periph_port_idle_req;
      mp_idle <= (mp_idle || go_mp_idle) && memory_port_idle_req;
    end
  end
  assign pp_idle_o = pp_idle;
  assign mp_idle_o = mp_idle;

  // ****************************************
  // Register writes and sticky flags
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      invalid_access_err_enable <= INV_ERR_EN_RST;
      write_posting_enable      <= WPE_RST;
      periph_timeout_enable     <= TIMEOUT_CONTROL_REG_RST[PERI_TO_EN_BIT];
      ext_mem_timeout_enable    <= TIMEOUT_CONTROL_REG_RST[EXT_TO_EN_BIT];
      periph_port_idle_req      <= ICR_RST[PERI_IDLE_REQ_BIT];
      memory_port_idle_req      <= ICR_RST[MEM_IDLE_REQ_BIT];
    end else if (reg_wr_i) begin
      if (sel_ppc) invalid_access_err_enable <= reg_wdata_i[INV_ERR_EN_BIT];
      if (sel_mpc) write_posting_enable <= reg_wdata_i[WPE_BIT];
      if (sel_toc) begin
        periph_timeout_enable  <= reg_wdata_i[PERI_TO_EN_BIT];
        ext_mem_timeout_enable <= reg_wdata_i[EXT_TO_EN_BIT];
      end
      if (sel_icr) begin
        periph_port_idle_req <= reg_wdata_i[PERI_IDLE_REQ_BIT];
        memory_port_idle_req <= reg_wdata_i[MEM_IDLE_REQ_BIT];
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      invalid_access_err_flag <= 1'b0;
      write_bus_err_flag      <= 1'b0;
      read_bus_err_flag       <= 1'b0;
      periph_timeout_flag     <= 1'b0;
      ext_mem_timeout_flag    <= 1'b0;
      bus_error_o             <= 1'b0;
    end else begin
      invalid_access_err_flag <= invalid_access_err_flag || inv_err;
      write_bus_err_flag      <= write_bus_err_flag || (inv_err && pp_write_i);
      read_bus_err_flag       <= read_bus_err_flag || (inv_err && !pp_write_i);
      periph_timeout_flag     <= periph_timeout_flag || pp_to;
      ext_mem_timeout_flag    <= ext_mem_timeout_flag || mp_to;
      bus_error_o             <= inv_err || pp_to || mp_to || idle_err;
    end
  end

  // ****************************************
  // Read back
  // ****************************************
  wire [15:0] ppc_val = 16'(invalid_access_err_enable) << INV_ERR_EN_BIT;
  wire [15:0] ppe_val = (16'(invalid_access_err_flag) << INV_ERR_FLAG_BIT) |
                        (16'(periph_timeout_flag) << PERI_TO_FLAG_BIT) |
                        (16'(write_bus_err_flag) << WR_BUS_ERR_BIT) |
                        (16'(read_bus_err_flag) << RD_BUS_ERR_BIT);
  wire [15:0] mpc_val = 16'(write_posting_enable) << WPE_BIT;
  wire [15:0] mpe_val = 16'(ext_mem_timeout_flag) << EXT_TO_FLAG_BIT;
  wire [15:0] toc_val = (16'(periph_timeout_enable) << PERI_TO_EN_BIT) |
                        (16'(ext_mem_timeout_enable) << EXT_TO_EN_BIT);
  wire [15:0] icr_val = (16'(periph_port_idle_req) << PERI_IDLE_REQ_BIT) |
                        (16'(memory_port_idle_req) << MEM_IDLE_REQ_BIT);

  // Unmapped addresses and reserved bits read zero
  wire [15:0] next_rdata = sel_ppc ? ppc_val : sel_ppe ? ppe_val : sel_mpc ? mpc_val :
                           sel_mpe ? mpe_val : sel_toc ? toc_val : sel_icr ? icr_val : 16'h0000;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= reg_rd_i ? next_rdata : 16'h0000;
    end
  end
  assign reg_rdata_o = rdata;

endmodule : ipm_top

// File: test/ipm_far_model.sv
// Far side model: a peripheral that answers late or never, and a memory interface.
// Assumes the controls from the bench change just after a rising edge.
`timescale 1ns/100ps
module ipm_far_model (
  input  wire logic clk_sys_i,
  input  wire logic req_i,
  input  wire logic dead_i,
  input  wire logic hold_i,
  input  wire logic hang_i,
  output logic      ack_o,
  output logic      ready_o,
  output logic      busy_o
);
  logic [1:0] age;
  always_ff @(posedge clk_sys_i) begin
    age <= req_i ? age + 2'h1 : 2'h0;
  end
  // A disabled peripheral never answers
  assign ack_o   = req_i && !dead_i && age == 2'h3;
  assign ready_o = !hold_i;
  assign busy_o  = hang_i;
endmodule : ipm_far_model

// File: test/ipm_top_monitor.sv
// Port checker of the internal port error monitor.
// Assumes it is bound into ipm_top; register shadows follow the register port.
`timescale 1ns/100ps
module ipm_top_monitor
  import ipm_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [15:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic        pp_req_i,
  input wire logic [15:0] pp_addr_i,
  input wire logic        pp_invalid_i,
  input wire logic        pp_stall_o,
  input wire logic        pp_req_o,
  input wire logic        pp_ack_i,
  input wire logic        idle_instr_i,
  input wire logic        cpu_idle_i,
  input wire logic        master_idle_i,
  input wire logic        pp_idle_o,
  input wire logic        mp_idle_o,
  input wire logic        emi_wr_o,
  input wire logic        emi_ready_i,
  input wire logic        bus_error_o
);
  // *****
  // Shadows
  // *****
  logic       en_q;
  logic       pto_q;
  logic [1:0] idle_q;
  logic [9:0] wait_cnt;
  wire logic  in_rng   = pp_addr_i <= RANGE0_HI || (pp_addr_i >= RANGE1_LO && pp_addr_i <= RANGE1_HI)
                         || (pp_addr_i >= RANGE2_LO && pp_addr_i <= RANGE2_HI);
  wire logic  all_idle = cpu_idle_i && master_idle_i;

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      en_q   <= INV_ERR_EN_RST;
      pto_q  <= 1'b0;
      idle_q <= ICR_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == PERIPH_PORT_CONFIG_OFS) en_q <= reg_wdata_i[INV_ERR_EN_BIT];
      if (reg_addr_i == TIMEOUT_CONTROL_OFS) pto_q <= reg_wdata_i[PERI_TO_EN_BIT];
      if (reg_addr_i == IDLE_CONTROL_OFS) idle_q <= reg_wdata_i[1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !pp_req_o || pp_ack_i) begin
      wait_cnt <= 10'h000;
    end else begin
      wait_cnt <= wait_cnt + 10'h001;
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence bad_req;
    pp_req_i && pp_invalid_i && in_rng && !pp_idle_o;
  endsequence
  sequence idle_cmd(req, state);
    idle_instr_i && req && !state && !all_idle;
  endsequence

  inv_err_a:
    assert property (bad_req ##0 en_q |=> bus_error_o) else $error("invalid access gave no bus error");
  no_fwd_a:
    assert property (bad_req |-> !pp_req_o) else $error("invalid access was forwarded");
  hang_a:
    assert property (bad_req ##0 !en_q |-> pp_stall_o ##1 !bus_error_o) else $error("disabled error did not hang");
  idle_block_a:
    assert property (pp_idle_o && pp_req_i |-> pp_stall_o && !pp_req_o ##1 !bus_error_o)
    else $error("idle peripheral port answered");
  pp_idle_err_a:
    assert property (idle_cmd(idle_q[PERI_IDLE_REQ_BIT], pp_idle_o) |=> pp_idle_o && bus_error_o)
    else $error("peripheral idle entry error missing");
  mp_idle_err_a:
    assert property (idle_cmd(idle_q[MEM_IDLE_REQ_BIT], mp_idle_o) |=> mp_idle_o && bus_error_o)
    else $error("memory idle entry error missing");
  err_pulse_a:
    assert property (bus_error_o |=> !bus_error_o) else $error("bus error longer than one cycle");
  rd_win_a:
    assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000) else $error("read data outside its cycle");
  to_bound_a:
    assert property (pto_q |-> wait_cnt <= 10'h208) else $error("peripheral wait outlived time-out");
  pop_a:
    assert property (emi_wr_o |-> $past(emi_ready_i) && !$past(mp_idle_o)) else $error("write issued without ready");
endmodule : ipm_top_monitor

bind ipm_top ipm_top_monitor mon (
  .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .pp_req_i, .pp_addr_i, .pp_invalid_i, .pp_stall_o, .pp_req_o, .pp_ack_i, .idle_instr_i,
  .cpu_idle_i, .master_idle_i, .pp_idle_o, .mp_idle_o, .emi_wr_o, .emi_ready_i, .bus_error_o
);

// File: test/tb.sv
// Self-checking bench of the internal port error monitor.
// Assumes ipm_top beside its far side model; tasks start just after a rising edge.
`timescale 1ns/100ps
module tb
  import ipm_pkg::*;
;
  logic        clk_sys_i, rst_n_i, reg_wr_i, reg_rd_i, pp_req_i, pp_write_i, pp_invalid_i, idle_instr_i;
  logic        cpu_idle_i, master_idle_i, wr_e_i, wr_f_i, dead, hold, hang;
  logic        pp_stall_o, pp_req_o, pp_ack_i, pp_idle_o, mp_idle_o, mp_stall_o;
  logic        emi_wr_o, emi_ready_i, emi_busy_i, bus_error_o;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, pp_addr_i, wr_e_data_i, wr_f_data_i, emi_data_o;
  logic [23:0] wr_e_addr_i, wr_f_addr_i, emi_addr_o;
  logic [39:0] mq[$];
  int          fail_count, n_compared, n_err, waited, t0;
  logic [15:0] ra[7] = '{16'h0100, 16'h0102, 16'h0200, 16'h0202, 16'h9000, 16'h0001, 16'h0300};
  logic [15:0] rv[7] = '{16'h8000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] rw[7] = '{16'h8000, 16'h0000, 16'h0080, 16'h0000, 16'h0003, 16'h0003, 16'h0000};
  logic [15:0] adr[9] = '{16'h0400, 16'h13ff, 16'h2400, 16'h0000, 16'h03ff, 16'h1400, 16'h17ff, 16'h2000,
                          16'h23ff};
  logic [2:0]  idl[3] = '{3'h1, 3'h6, 3'h7};
  logic [39:0] em[4] = '{40'h0001001111, 40'h0002002222, 40'h0003003333, 40'h0004004444};

  ipm_top dut (
    .clk_sys_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .pp_req_i,
    .pp_write_i, .pp_addr_i, .pp_invalid_i, .pp_stall_o, .pp_req_o, .pp_ack_i, .idle_instr_i, .cpu_idle_i,
    .master_idle_i, .pp_idle_o, .mp_idle_o, .wr_e_i, .wr_e_addr_i, .wr_e_data_i, .wr_f_i, .wr_f_addr_i,
    .wr_f_data_i, .mp_stall_o, .emi_wr_o, .emi_addr_o, .emi_data_o, .emi_ready_i, .emi_busy_i, .bus_error_o);
  ipm_far_model far (.clk_sys_i, .req_i(pp_req_o), .dead_i(dead), .hold_i(hold), .hang_i(hang),
    .ack_o(pp_ack_i), .ready_o(emi_ready_i), .busy_o(emi_busy_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  // Error pulses and memory writes are logged as they appear
  always @(negedge clk_sys_i) begin
    if (bus_error_o === 1'b1) n_err++;
    if (emi_wr_o === 1'b1) mq.push_back({emi_addr_o, emi_data_o});
  end

  // *****
  // Tasks
  // *****
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  task automatic rdchk(input logic [15:0] a, input logic [15:0] e);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, e);
    @(posedge clk_sys_i);
  endtask : rdchk
  task automatic wait_free(input logic m, input int lim);
    waited = 0;
    #1;
    while ((m ? mp_stall_o : pp_stall_o) !== 1'b0 && waited < lim) begin
      @(posedge clk_sys_i);
      #1;
      waited++;
    end
    @(posedge clk_sys_i);
  endtask : wait_free
  task automatic pp(input logic [15:0] a, input logic w, input logic inv, input int lim);
    pp_addr_i <= a;
    pp_write_i <= w;
    pp_invalid_i <= inv;
    pp_req_i <= 1'b1;
    wait_free(1'b0, lim);
    pp_req_i <= 1'b0;
  endtask : pp
  task automatic mw(input logic f, input logic [23:0] a, input logic [15:0] d, input int lim);
    wr_e_i <= !f;
    wr_f_i <= f;
    {wr_e_addr_i, wr_f_addr_i, wr_e_data_i, wr_f_data_i} <= {a, a, d, d};
    wait_free(1'b1, lim);
    wr_e_i <= 1'b0;
    wr_f_i <= 1'b0;
  endtask : mw
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (6000) @(posedge clk_sys_i);
    fail_count++;
    stop_test;
  end

  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, pp_req_i, pp_write_i, pp_invalid_i, idle_instr_i} <= '0;
    {cpu_idle_i, master_idle_i, wr_e_i, wr_f_i, dead, hold, hang} <= '0;
    {reg_addr_i, reg_wdata_i, pp_addr_i, wr_e_data_i, wr_f_data_i, wr_e_addr_i, wr_f_addr_i} <= '0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    for (int i = 0; i < 7; i++) begin
      rdchk(ra[i], rv[i]);
      wr(ra[i], 16'hffff);
      rdchk(ra[i], rw[i]);
    end
    wr(IDLE_CONTROL_OFS, 16'h0000);
    wr(MEMORY_PORT_CONFIG_OFS, 16'h0000);
    for (int i = 0; i < 9; i++) begin
      t0 = n_err;
      pp(adr[i], i[0], 1'b1, 20);
      repeat (2) @(posedge clk_sys_i);
      check(n_err - t0, i > 2);
      if (i == 2 || i == 3) rdchk(PERIPH_PORT_ERROR_STATUS_OFS, i == 3 ? 16'h8010 : 16'h0000);
    end
    rdchk(PERIPH_PORT_ERROR_STATUS_OFS, 16'h8018);
    for (int i = 0; i < 3; i++) begin
      wr(IDLE_CONTROL_OFS, idl[i][2] ? 16'h0002 : 16'h0001);
      {cpu_idle_i, master_idle_i, idle_instr_i} <= {idl[i][1:0], 1'b1};
      t0 = n_err;
      @(posedge clk_sys_i);
      idle_instr_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      check({pp_idle_o, mp_idle_o}, idl[i][2] ? 2'b01 : 2'b10);
      check(n_err - t0, idl[i][1:0] != 2'b11);
      t0 = n_err;
      if (idl[i][2]) mw(1'b0, 24'h000040, 16'h0bad, 6);
      else pp(16'h0010, 1'b0, 1'b1, 6);
      check(waited, 6);
      check(n_err - t0, 0);
      wr(IDLE_CONTROL_OFS, 16'h0000);
      repeat (2) @(posedge clk_sys_i);
      check({pp_idle_o, mp_idle_o}, 2'b00);
    end
    {cpu_idle_i, master_idle_i} <= 2'b00;
    wr(TIMEOUT_CONTROL_OFS, 16'h0002);
    dead <= 1'b1;
    t0 = n_err;
    pp(16'h0500, 1'b0, 1'b0, 600);
    repeat (2) @(posedge clk_sys_i);
    check(waited > 500 && waited < 520, 1'b1);
    check(n_err - t0, 1);
    rdchk(PERIPH_PORT_ERROR_STATUS_OFS, 16'h9018);
    dead <= 1'b0;
    wr(TIMEOUT_CONTROL_OFS, 16'h0001);
    hang <= 1'b1;
    t0 = n_err;
    waited = 0;
    while (n_err == t0 && waited < 600) begin
      @(posedge clk_sys_i);
      waited++;
    end
    hang <= 1'b0;
    check(waited > 500 && waited < 520, 1'b1);
    rdchk(MEMORY_PORT_ERROR_STATUS_OFS, 16'h1000);
    mq.delete();
    for (int i = 0; i < 4; i++) begin
      hold <= 1'b1;
      if (i == 1) wr(MEMORY_PORT_CONFIG_OFS, 16'h0080);
      fork
        mw(i == 2, em[i][39:16], em[i][15:0], 40);
        if (i == 0 || i == 3) begin
          repeat (4) @(posedge clk_sys_i);
          hold <= 1'b0;
        end
      join
      check(waited >= 3, i == 0 || i == 3);
      repeat (i == 0 ? 4 : 1) @(posedge clk_sys_i);
    end
    repeat (8) @(posedge clk_sys_i);
    check(mq.size(), 4);
    for (int i = 0; i < 4; i++) check(mq[i], em[i]);
    wr(PERIPH_PORT_CONFIG_OFS, 16'h0000);
    t0 = n_err;
    pp(16'h2010, 1'b1, 1'b1, 20);
    check(waited, 20);
    check(n_err - t0, 0);
    rdchk(PERIPH_PORT_ERROR_STATUS_OFS, 16'h9018);
    rst_n_i <= 1'b0;
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdchk(PERIPH_PORT_ERROR_STATUS_OFS, 16'h0000);
    rdchk(PERIPH_PORT_CONFIG_OFS, 16'h8000);
    stop_test;
  end
endmodule : tb
